// *** pkg/serial_status_pkg.sv ***
/*
 * Constants shared by the serial port status-flag logic: register
 * offsets, field positions, reset values and character lengths.
 * Assumes a byte-wide register port with one-cycle strobes.
 */
package serial_status_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [1:0] STATUS_OFS  = 2'h0;
    localparam logic [1:0] CONTROL_OFS = 2'h1;
    localparam logic [1:0] DATA_OFS    = 2'h2;

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int TX_EMPTY_BIT = 7;
    localparam int TX_DONE_BIT  = 6;
    localparam int RX_FULL_BIT  = 5;
    localparam int IDLE_BIT     = 4;
    localparam int OVERRUN_BIT  = 3;
    localparam int NOISE_BIT    = 2;
    localparam int FRAME_BIT    = 1;
    localparam int PARITY_BIT   = 0;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int BREAK_BIT    = 0;
    localparam int TX_ON_BIT    = 1;
    localparam int PARITY_ON_BIT = 2;
    localparam int IDLE_SEL_BIT = 3;
    localparam int NINE_BIT_BIT = 4;
    localparam int LONG_BRK_BIT = 5;

    // ------------------------------------------------------------
    // reset values and character lengths
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET  = 8'hC0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [3:0] CHAR_BITS_8   = 4'hA;
    localparam logic [3:0] CHAR_BITS_9   = 4'hB;

endpackage : serial_status_pkg

// *** design/serial_status_flags.sv ***
/*
 * Status-flag logic of an asynchronous serial port: transmit empty,
 * transmit done, receive full, idle line, overrun, noise, framing and
 * parity flags, with their read-then-access clearing sequences.
 * Assumes the transmitter and receiver state machines sit outside and
 * report events as one-cycle pulses synchronous to CLK.
 */
// Operation
// - transmit empty flag, bit 7, is 1 after reset and sets on shift load
// - transmit empty clears only by status read seeing 1 then data write
// - transmit done, bit 6, is 1 after reset; sets when empty and idle
// - armed transmit done clears on data write, enable rise or break queue
// - receive full, bit 5, sets when a character reaches the data register
// - receive full clears by status read seeing 1 then data read
// - idle flag, bit 4, sets after 10 or 11 high bit times
// - idle select 0: idle count starts after the start bit
// - idle select 1: idle count starts only after the stop bit
// - idle flag clears by status read seeing 1 then data read
// - after clearing, idle sets again only after a new received character
// - overrun, bit 3, sets when a character arrives unread; new one dropped
// - overrun clears by status read seeing 1 then data read
// - any disagreeing sample within a bit sets noise, bit 2, with full
// - noise clears by status read then data read
// - framing error, bit 1, sets with full on a low stop bit
// - framing error clears by status read seeing 1 then data read
// - parity error, bit 0, sets with full on mismatch when parity enabled
// - parity error clears by status read then data read
// - status register is read-only; writes do nothing
// - long break detection blocks framing error and receive full setting
module serial_status_flags
    import serial_status_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [1:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       TX_LOAD,
    input  wire logic       TX_BUSY,
    output logic      [7:0] TX_DATA,
    output logic            TX_DATA_VALID,
    output logic            TX_PREAMBLE_REQ,
    output logic            TX_BREAK_REQ,
    output logic            TX_ENABLE,
    output logic            NINE_BIT_MODE,
    input  wire logic       RX_LINE,
    input  wire logic       RX_BIT_TICK,
    input  wire logic       RX_START_DONE,
    input  wire logic       RX_STOP_DONE,
    input  wire logic       RX_SAMPLE_VALID,
    input  wire logic       RX_SAMPLE,
    input  wire logic       RX_BIT_END,
    input  wire logic       RX_CHAR_DONE,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_STOP_LOW,
    input  wire logic       RX_PARITY_BAD
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] flags_reg,     flags_next;
    logic [7:0] arm_reg,       arm_next;
    logic [7:0] ctrl_reg,      ctrl_next;
    logic [7:0] rx_buf_reg,    rx_buf_next;
    logic [7:0] tx_buf_reg,    tx_buf_next;
    logic       tx_valid_reg,  tx_valid_next;
    logic       pre_reg,       pre_next;
    logic       tx_pend_reg,   tx_pend_next;
    logic [7:0] rdata_reg,     rdata_next;
    logic       first_reg,     first_next;
    logic       first_val_reg, first_val_next;
    logic       bit_noise_reg, bit_noise_next;
    logic       frm_noise_reg, frm_noise_next;
    logic [3:0] idle_cnt_reg,  idle_cnt_next;
    logic       counting_reg,  counting_next;
    logic       idle_ok_reg,   idle_ok_next;

    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic       stat_rd, data_rd, data_wr, ctrl_wr;
    logic       rx_xfer, tx_rise, brk_wr, tc_clr_act;
    logic       samp_diff, char_noise, idle_hit;
    logic [3:0] char_len;

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    assign stat_rd = RD && (ADDR == STATUS_OFS);
    assign data_rd = RD && (ADDR == DATA_OFS);
    assign data_wr = WR && (ADDR == DATA_OFS);
    assign ctrl_wr = WR && (ADDR == CONTROL_OFS);

    assign tx_rise = ctrl_wr && WDATA[TX_ON_BIT] && !ctrl_reg[TX_ON_BIT];
    assign brk_wr  = ctrl_wr && WDATA[BREAK_BIT];
    assign tc_clr_act = data_wr || tx_rise || brk_wr;
    assign char_len = ctrl_reg[NINE_BIT_BIT] ? CHAR_BITS_9 : CHAR_BITS_8;

    // ------------------------------------------------------------
    // receive sampling and idle detection
    // ------------------------------------------------------------
    assign samp_diff  = RX_SAMPLE_VALID && !first_reg &&
                        (RX_SAMPLE != first_val_reg);
    assign char_noise = frm_noise_reg || bit_noise_reg || samp_diff;
    assign rx_xfer    = RX_CHAR_DONE && !flags_reg[RX_FULL_BIT]
                        && !ctrl_reg[LONG_BRK_BIT];
    assign idle_hit   = counting_reg && RX_BIT_TICK && RX_LINE &&
                        (idle_cnt_reg + 4'h1 == char_len);

    always_comb begin
        first_next     = first_reg;
        first_val_next = first_val_reg;
        bit_noise_next = bit_noise_reg || samp_diff;
        frm_noise_next = frm_noise_reg;
        if (RX_SAMPLE_VALID && first_reg) begin
            first_val_next = RX_SAMPLE;
            first_next     = 1'b0;
        end
        if (RX_BIT_END) begin
            frm_noise_next = frm_noise_reg || bit_noise_reg || samp_diff;
            bit_noise_next = 1'b0;
            first_next     = 1'b1;
        end
        if (RX_CHAR_DONE) begin
            frm_noise_next = 1'b0;
            bit_noise_next = 1'b0;
            first_next     = 1'b1;
        end

        idle_cnt_next = idle_cnt_reg;
        counting_next = counting_reg;
        if (RX_BIT_TICK && counting_reg) begin
            idle_cnt_next = RX_LINE ? idle_cnt_reg + 4'h1 : 4'h0;
        end
        if (idle_hit) begin
            counting_next = 1'b0;
            idle_cnt_next = 4'h0;
        end
        if (RX_START_DONE) begin
            counting_next = !ctrl_reg[IDLE_SEL_BIT];
            idle_cnt_next = 4'h0;
        end
        if (RX_STOP_DONE && ctrl_reg[IDLE_SEL_BIT]) begin
            counting_next = 1'b1;
            idle_cnt_next = 4'h0;
        end

        idle_ok_next = idle_ok_reg;
        if (idle_hit) begin
            idle_ok_next = 1'b0;
        end
        if (rx_xfer) begin
            idle_ok_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // flag set and clear events
    // ------------------------------------------------------------
    always_comb begin
        set_ev = 8'h00;
        set_ev[TX_EMPTY_BIT] = TX_LOAD;
        set_ev[TX_DONE_BIT]  = flags_reg[TX_EMPTY_BIT] && !TX_BUSY
                               && !tx_pend_reg && !tc_clr_act;
        set_ev[RX_FULL_BIT]  = rx_xfer;
        set_ev[IDLE_BIT]     = idle_hit && idle_ok_reg;
        set_ev[OVERRUN_BIT]  = RX_CHAR_DONE
                               && flags_reg[RX_FULL_BIT];
        set_ev[NOISE_BIT]    = rx_xfer && char_noise;
        set_ev[FRAME_BIT]    = rx_xfer && RX_STOP_LOW;
        set_ev[PARITY_BIT]   = rx_xfer && RX_PARITY_BAD
                               && ctrl_reg[PARITY_ON_BIT];

        clr_ev = 8'h00;
        clr_ev[TX_EMPTY_BIT] = data_wr;
        clr_ev[TX_DONE_BIT]  = tc_clr_act;
        clr_ev[RX_FULL_BIT]  = data_rd;
        clr_ev[IDLE_BIT]     = data_rd;
        clr_ev[OVERRUN_BIT]  = data_rd;
        clr_ev[NOISE_BIT]    = data_rd;
        clr_ev[FRAME_BIT]    = data_rd;
        clr_ev[PARITY_BIT]   = data_rd;
    end

    // ------------------------------------------------------------
    // flags, arming and register file
    // ------------------------------------------------------------
    always_comb begin
        // status writes are not decoded at all
        flags_next = (flags_reg & ~(arm_reg & clr_ev)) | set_ev;
        arm_next   = arm_reg & ~clr_ev;
        if (stat_rd) begin
            arm_next = flags_reg;
            arm_next[NOISE_BIT]  = 1'b1;
            arm_next[PARITY_BIT] = 1'b1;
        end
        // only a rising flag disarms; a level set must stay clearable
        arm_next = arm_next & ~(set_ev & ~flags_reg);

        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next = WDATA;
        end

        rx_buf_next = rx_xfer ? RX_DATA : rx_buf_reg;
        tx_buf_next = data_wr ? WDATA : tx_buf_reg;
        tx_valid_next = data_wr;
        pre_next    = tx_rise;

        tx_pend_next = tx_pend_reg;
        if (TX_BUSY) begin
            tx_pend_next = 1'b0;
        end
        if (tc_clr_act && arm_reg[TX_DONE_BIT]) begin
            tx_pend_next = 1'b1;
        end

        case (ADDR)
            STATUS_OFS:  rdata_next = flags_reg;
            CONTROL_OFS: rdata_next = ctrl_reg;
            DATA_OFS:    rdata_next = rx_buf_reg;
            default:     rdata_next = 8'h00;
        endcase
        if (!RD) begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            flags_reg     <= STATUS_RESET;
            arm_reg       <= 8'h00;
            ctrl_reg      <= CONTROL_RESET;
            rx_buf_reg    <= 8'h00;
            tx_buf_reg    <= 8'h00;
            tx_valid_reg  <= 1'b0;
            pre_reg       <= 1'b0;
            tx_pend_reg   <= 1'b0;
            rdata_reg     <= 8'h00;
            first_reg     <= 1'b1;
            first_val_reg <= 1'b1;
            bit_noise_reg <= 1'b0;
            frm_noise_reg <= 1'b0;
            idle_cnt_reg  <= 4'h0;
            counting_reg  <= 1'b0;
            idle_ok_reg   <= 1'b0;
        end else begin
            flags_reg     <= flags_next;
            arm_reg       <= arm_next;
            ctrl_reg      <= ctrl_next;
            rx_buf_reg    <= rx_buf_next;
            tx_buf_reg    <= tx_buf_next;
            tx_valid_reg  <= tx_valid_next;
            pre_reg       <= pre_next;
            tx_pend_reg   <= tx_pend_next;
            rdata_reg     <= rdata_next;
            first_reg     <= first_next;
            first_val_reg <= first_val_next;
            bit_noise_reg <= bit_noise_next;
            frm_noise_reg <= frm_noise_next;
            idle_cnt_reg  <= idle_cnt_next;
            counting_reg  <= counting_next;
            idle_ok_reg   <= idle_ok_next;
        end
    end

    assign RDATA           = rdata_reg;
    assign TX_DATA         = tx_buf_reg;
    assign TX_DATA_VALID   = tx_valid_reg;
    assign TX_PREAMBLE_REQ = pre_reg;
    assign TX_BREAK_REQ    = ctrl_reg[BREAK_BIT];
    assign TX_ENABLE       = ctrl_reg[TX_ON_BIT];
    assign NINE_BIT_MODE   = ctrl_reg[NINE_BIT_BIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_tx_empty_set: assert property (@(posedge CLK) disable iff (RST)
        TX_LOAD |=> flags_reg[TX_EMPTY_BIT])
        else $error("transmit empty did not set on load");

    a_tx_empty_clr: assert property (@(posedge CLK) disable iff (RST)
        $fell(flags_reg[TX_EMPTY_BIT]) |-> $past(data_wr)
            && $past(arm_reg[TX_EMPTY_BIT]))
        else $error("transmit empty cleared without sequence");

    a_tx_done_clr: assert property (@(posedge CLK) disable iff (RST)
        $fell(flags_reg[TX_DONE_BIT]) |-> $past(tc_clr_act)
            && $past(arm_reg[TX_DONE_BIT]))
        else $error("transmit done cleared without sequence");

    a_rx_full_set: assert property (@(posedge CLK) disable iff (RST)
        RX_CHAR_DONE && ctrl_reg[LONG_BRK_BIT] && !flags_reg[RX_FULL_BIT]
            |=> !flags_reg[RX_FULL_BIT] && !flags_reg[FRAME_BIT]
            || $past(flags_reg[FRAME_BIT]))
        else $error("full or framing set during long break detect");

    a_rx_full_clr: assert property (@(posedge CLK) disable iff (RST)
        stat_rd && flags_reg[RX_FULL_BIT] ##1 data_rd && !RX_CHAR_DONE
            |=> !flags_reg[RX_FULL_BIT])
        else $error("receive full not cleared by sequence");

    a_overrun_keep: assert property (@(posedge CLK) disable iff (RST)
        RX_CHAR_DONE && flags_reg[RX_FULL_BIT]
            |=> flags_reg[OVERRUN_BIT] && $stable(rx_buf_reg))
        else $error("overrun not flagged or data overwritten");

    a_idle_once: assert property (@(posedge CLK) disable iff (RST)
        idle_hit && !idle_ok_reg |=> !$rose(flags_reg[IDLE_BIT]))
        else $error("idle set twice without new character");

    a_noise_with: assert property (@(posedge CLK) disable iff (RST)
        $rose(flags_reg[NOISE_BIT]) |-> $rose(flags_reg[RX_FULL_BIT]))
        else $error("noise set apart from receive full");

    a_parity_gate: assert property (@(posedge CLK) disable iff (RST)
        rx_xfer && RX_PARITY_BAD && ctrl_reg[PARITY_ON_BIT]
            |=> flags_reg[PARITY_BIT])
        else $error("parity error not flagged");

    a_late_set: assert property (@(posedge CLK) disable iff (RST)
        stat_rd && !flags_reg[FRAME_BIT] ##1 set_ev[FRAME_BIT] ##1 data_rd
            |=> flags_reg[FRAME_BIT])
        else $error("late framing error cleared by armed read");

    a_status_ro: assert property (@(posedge CLK) disable iff (RST)
        WR && ADDR == STATUS_OFS && set_ev == 8'h00 && !data_wr
            |=> flags_reg == $past(flags_reg))
        else $error("status write changed flags");

endmodule : serial_status_flags

// *** verif/remote_serial_node.sv ***
/*
 * Behavioural model of the far side of the status-flag block: the
 * transmit shifter that takes buffered bytes and the receiver front end
 * that reports samples, bit ticks and finished characters.
 * Assumes the bench calls send_char and idle_bits between bus accesses.
 */
module remote_serial_node (
    input  wire logic       clk,
    input  wire logic       tx_data_valid,
    input  wire logic       tx_preamble_req,
    input  wire logic       tx_break_req,
    output logic            tx_load,
    output logic            tx_busy,
    output logic            rx_line,
    output logic            rx_bit_tick,
    output logic            rx_start_done,
    output logic            rx_stop_done,
    output logic            rx_sample_valid,
    output logic            rx_sample,
    output logic            rx_bit_end,
    output logic            rx_char_done,
    output logic      [7:0] rx_data,
    output logic            rx_stop_low,
    output logic            rx_parity_bad
);
    timeunit 1ns;
    timeprecision 100ps;

    int   tx_delay   = 30;
    logic shift_busy = 1'b0;

    initial begin
        {tx_load, rx_bit_tick, rx_start_done, rx_stop_done} = 4'h0;
        {rx_sample_valid, rx_bit_end, rx_char_done} = 3'h0;
        {rx_line, rx_sample, rx_stop_low, rx_parity_bad} = 4'hC;
        rx_data = 8'h00;
    end

    // ------------------------------------------------------------
    // transmit shifter: break keeps the line busy while queued
    // ------------------------------------------------------------
    assign tx_busy = shift_busy | tx_break_req;

    always begin : tx_side
        logic with_data;
        @(posedge clk);
        with_data = tx_data_valid;
        if (with_data === 1'b1 || tx_preamble_req === 1'b1) begin
            repeat (tx_delay) @(posedge clk);
            tx_load <= with_data;
            shift_busy <= 1'b1;
            @(posedge clk);
            tx_load <= 1'b0;
            repeat (16) @(posedge clk);
            shift_busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // receiver front end
    // ------------------------------------------------------------
    task automatic rx_bit(input logic v, input int n, input logic noisy);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_line <= v;
            rx_sample_valid <= 1'b1;
            rx_sample <= (noisy && i == n - 1) ? ~v : v;
        end
        @(posedge clk);
        rx_sample_valid <= 1'b0;
        rx_sample <= ~v;
        rx_bit_end <= 1'b1;
        rx_bit_tick <= 1'b1;
        @(posedge clk);
        rx_bit_end <= 1'b0;
        rx_bit_tick <= 1'b0;
    endtask : rx_bit

    // lsb first, noise only ever injected in the start bit
    task automatic send_char(input logic [7:0] b, input logic stop_low,
                             input logic par_bad, input logic noisy);
        rx_bit(1'b0, 7, noisy);
        rx_start_done <= 1'b1;
        @(posedge clk);
        rx_start_done <= 1'b0;
        for (int i = 0; i < 8; i++) rx_bit(b[i], 3, 1'b0);
        rx_bit(~stop_low, 3, 1'b0);
        rx_data <= b;
        rx_stop_low <= stop_low;
        rx_parity_bad <= par_bad;
        rx_stop_done <= 1'b1;
        rx_char_done <= 1'b1;
        @(posedge clk);
        {rx_stop_done, rx_char_done} <= 2'h0;
        rx_data <= ~b;
        rx_stop_low <= ~stop_low;
        rx_parity_bad <= ~par_bad;
        rx_line <= 1'b1;
    endtask : send_char

    task automatic idle_bits(input int n);
        repeat (n) begin
            @(posedge clk);
            rx_bit_tick <= 1'b1;
            @(posedge clk);
            rx_bit_tick <= 1'b0;
        end
    endtask : idle_bits
endmodule : remote_serial_node

// *** verif/serial_port_status_flags_tb_top.sv ***
/*
 * Self-checking bench for the serial status-flag block: register tasks
 * on the byte port and sequences of transmit and receive events.
 * Assumes remote_serial_node stands at the event side.
 */
module serial_port_status_flags_tb_top import serial_status_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic       CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [1:0] ADDR = 2'h0;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA, TX_DATA, RX_DATA;
    logic       TX_LOAD, TX_BUSY, TX_DATA_VALID, TX_PREAMBLE_REQ;
    logic       TX_BREAK_REQ, TX_ENABLE, NINE_BIT_MODE, RX_LINE;
    logic       RX_BIT_TICK, RX_START_DONE, RX_STOP_DONE, RX_SAMPLE;
    logic       RX_SAMPLE_VALID, RX_BIT_END, RX_CHAR_DONE;
    logic       RX_STOP_LOW, RX_PARITY_BAD;
    int         bad_count = 0;
    int         checks    = 0;

    initial begin
        forever #4 CLK = ~CLK;
    end

    serial_status_flags serial_status_flags_inst (
        .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .TX_LOAD(TX_LOAD), .TX_BUSY(TX_BUSY),
        .TX_DATA(TX_DATA), .TX_DATA_VALID(TX_DATA_VALID),
        .TX_PREAMBLE_REQ(TX_PREAMBLE_REQ), .TX_BREAK_REQ(TX_BREAK_REQ),
        .TX_ENABLE(TX_ENABLE), .NINE_BIT_MODE(NINE_BIT_MODE),
        .RX_LINE(RX_LINE), .RX_BIT_TICK(RX_BIT_TICK),
        .RX_START_DONE(RX_START_DONE), .RX_STOP_DONE(RX_STOP_DONE),
        .RX_SAMPLE_VALID(RX_SAMPLE_VALID), .RX_SAMPLE(RX_SAMPLE),
        .RX_BIT_END(RX_BIT_END), .RX_CHAR_DONE(RX_CHAR_DONE),
        .RX_DATA(RX_DATA), .RX_STOP_LOW(RX_STOP_LOW),
        .RX_PARITY_BAD(RX_PARITY_BAD));
    remote_serial_node remote_serial_node_inst (
        .clk(CLK), .tx_data_valid(TX_DATA_VALID),
        .tx_preamble_req(TX_PREAMBLE_REQ), .tx_break_req(TX_BREAK_REQ),
        .tx_load(TX_LOAD), .tx_busy(TX_BUSY), .rx_line(RX_LINE),
        .rx_bit_tick(RX_BIT_TICK), .rx_start_done(RX_START_DONE),
        .rx_stop_done(RX_STOP_DONE), .rx_sample_valid(RX_SAMPLE_VALID),
        .rx_sample(RX_SAMPLE), .rx_bit_end(RX_BIT_END),
        .rx_char_done(RX_CHAR_DONE), .rx_data(RX_DATA),
        .rx_stop_low(RX_STOP_LOW), .rx_parity_bad(RX_PARITY_BAD));

    // ------------------------------------------------------------
    // register port tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask : rd

    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic chk(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] got;
        rd(a, got);
        cmp(a == STATUS_OFS ? "status" : "register", exp, got);
    endtask : chk

    task automatic wait_status(input logic [7:0] exp);
        logic [7:0] got;
        for (int i = 0; i < 200; i++) begin
            rd(STATUS_OFS, got);
            if (got === exp) return;
        end
        cmp("status wait", exp, got);
        complete_run();
    endtask : wait_status

    task automatic complete_run();
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    initial begin
        repeat (100000) @(posedge CLK);
        bad_count++;
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        wr(STATUS_OFS, 8'hFF);
        wr(2'h3, 8'hFF);
        wr(DATA_OFS, 8'hA5);
        chk(STATUS_OFS, STATUS_RESET);
        chk(2'h3, 8'h00);
        repeat (60) @(posedge CLK);
        chk(STATUS_OFS, 8'hC0);
        cmp("tx data", 8'hA5, TX_DATA);
        chk(STATUS_OFS, 8'hC0);
        wr(DATA_OFS, 8'h55);
        cmp("tx data", 8'h55, TX_DATA);
        chk(STATUS_OFS, 8'h00);
        wait_status(8'h80);
        wait_status(8'hC0);
        remote_serial_node_inst.tx_delay = 1;
        chk(STATUS_OFS, 8'hC0);
        wr(CONTROL_OFS, 8'h02);
        chk(STATUS_OFS, 8'h80);
        cmp("tx enable", 8'h01, {7'h00, TX_ENABLE});
        wait_status(8'hC0);
        chk(STATUS_OFS, 8'hC0);
        wr(CONTROL_OFS, 8'h03);
        chk(STATUS_OFS, 8'h80);
        wr(CONTROL_OFS, 8'h02);
        wait_status(8'hC0);
        remote_serial_node_inst.send_char(8'h5A, 1'b0, 1'b0, 1'b0);
        chk(DATA_OFS, 8'h5A);
        chk(STATUS_OFS, 8'hE0);
        remote_serial_node_inst.send_char(8'h11, 1'b0, 1'b0, 1'b0);
        chk(DATA_OFS, 8'h5A);
        chk(STATUS_OFS, 8'hC8);
        remote_serial_node_inst.send_char(8'h22, 1'b0, 1'b1, 1'b1);
        chk(STATUS_OFS, 8'hEC);
        chk(DATA_OFS, 8'h22);
        chk(STATUS_OFS, 8'hC0);
        wr(CONTROL_OFS, 8'h06);
        remote_serial_node_inst.send_char(8'h33, 1'b1, 1'b1, 1'b1);
        chk(STATUS_OFS, 8'hE7);
        chk(DATA_OFS, 8'h33);
        chk(STATUS_OFS, 8'hC0);
        wr(CONTROL_OFS, 8'h02);
        remote_serial_node_inst.send_char(8'h44, 1'b0, 1'b1, 1'b0);
        chk(STATUS_OFS, 8'hE0);
        chk(DATA_OFS, 8'h44);
        wr(CONTROL_OFS, 8'h22);
        remote_serial_node_inst.send_char(8'h66, 1'b1, 1'b0, 1'b0);
        chk(STATUS_OFS, 8'hC0);
        wr(CONTROL_OFS, 8'h02);
        remote_serial_node_inst.send_char(8'hFF, 1'b0, 1'b0, 1'b0);
        chk(STATUS_OFS, 8'hE0);
        remote_serial_node_inst.idle_bits(1);
        chk(STATUS_OFS, 8'hF0);
        chk(DATA_OFS, 8'hFF);
        chk(STATUS_OFS, 8'hC0);
        remote_serial_node_inst.idle_bits(12);
        chk(STATUS_OFS, 8'hC0);
        wr(CONTROL_OFS, 8'h0A);
        remote_serial_node_inst.send_char(8'hFF, 1'b0, 1'b0, 1'b0);
        remote_serial_node_inst.idle_bits(9);
        chk(STATUS_OFS, 8'hE0);
        remote_serial_node_inst.idle_bits(1);
        chk(STATUS_OFS, 8'hF0);
        chk(DATA_OFS, 8'hFF);
        wr(CONTROL_OFS, 8'h12);
        cmp("nine bit", 8'h01, {7'h00, NINE_BIT_MODE});
        remote_serial_node_inst.send_char(8'hFF, 1'b0, 1'b0, 1'b0);
        remote_serial_node_inst.idle_bits(1);
        chk(STATUS_OFS, 8'hE0);
        remote_serial_node_inst.idle_bits(1);
        chk(STATUS_OFS, 8'hF0);
        chk(DATA_OFS, 8'hFF);
        chk(STATUS_OFS, 8'hC0);
        complete_run();
    end
endmodule : serial_port_status_flags_tb_top
